//--- logic/taa_pkg.sv
// constants, register map and field positions of the thread aging priority block
package taa_pkg;
    // ------------------------------------------------------------------
    // thread slots and age numbers
    // ------------------------------------------------------------------
    localparam int unsigned NUM_THREADS = 8;
    localparam int unsigned SLOT_W      = 3;
    localparam int unsigned AGE_W       = 3;
    localparam logic [AGE_W-1:0] AGE_RESET = 3'h0;
    // ------------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL        = 8'h00;
    localparam logic [7:0] OFS_THREAD_SEL  = 8'h04;
    localparam logic [7:0] OFS_STATE_WORD0 = 8'h08;
    localparam logic [7:0] OFS_RESIDENT    = 8'h0C;
    localparam logic [7:0] OFS_PICK        = 8'h10;
    localparam logic [7:0] OFS_LAUNCH_CNT  = 8'h14;
    localparam logic [7:0] OFS_RESTORE_CNT = 8'h18;
    // ------------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------------
    localparam int unsigned SW_CLASS_BIT   = 23;
    localparam int unsigned SW_AGE_LSB     = 20;
    localparam int unsigned SW_RSVD_MSB    = 19;
    localparam int unsigned SW_RSVD_LSB    = 14;
    localparam int unsigned SW_SLICE_LSB   = 11;
    localparam int unsigned SW_DSS_LSB     = 9;
    localparam int unsigned SW_SUBSL_BIT   = 8;
    localparam int unsigned CTRL_SCHED_BIT = 0;
    localparam int unsigned RES_CLASS_LSB  = 8;
    localparam int unsigned PICK_VALID_BIT = 8;
    localparam logic        CTRL_SCHED_RST = 1'b1;
    localparam logic [SLOT_W-1:0] SEL_RST  = 3'h0;
    localparam logic [31:0] CNT_RST        = 32'h0000_0000;
endpackage : taa_pkg

//--- logic/taa_reg_if.sv
// register access carrier between the bus front end and the core
`timescale 1ns/1ps
interface taa_reg_if;
    logic        wr_en;
    logic [7:0]  wr_addr;
    logic [31:0] wr_data;
    logic        rd_en;
    logic [7:0]  rd_addr;
    logic [31:0] rd_data;
    modport port (output wr_en, wr_addr, wr_data, rd_en, rd_addr,
                  input  rd_data);
    modport core (input  wr_en, wr_addr, wr_data, rd_en, rd_addr,
                  output rd_data);
endinterface : taa_reg_if

//--- logic/taa_ahb_port.sv
// ahb-lite slave front end: zero wait states, always okay
`timescale 1ns/1ps
module taa_ahb_port
    import taa_pkg::*;
(
    // clock and reset
    input  wire logic        ref_clk_in,
    input  wire logic        sys_rst_in,
    // ahb-lite slave
    input  wire logic        hsel_in,
    input  wire logic [31:0] haddr_in,
    input  wire logic [1:0]  htrans_in,
    input  wire logic        hwrite_in,
    input  wire logic [2:0]  hsize_in,
    input  wire logic [31:0] hwdata_in,
    input  wire logic        hready_in,
    output logic             hreadyout_out,
    output logic             hresp_out,
    output logic [31:0]      hrdata_out,
    // core side
    taa_reg_if.port          regs
);
    logic        ap_take;
    logic        wr_pend_q;
    logic        wr_pend_d;
    logic [7:0]  wr_addr_q;
    logic [7:0]  wr_addr_d;
    logic [31:0] hrdata_q;
    logic [31:0] hrdata_d;

    // ------------------------------------------------------------------
    // address phase capture, read data registered for the data phase
    // ------------------------------------------------------------------
    always_comb begin
        ap_take   = hsel_in && htrans_in[1] && hready_in
                    && (hsize_in == 3'h2);
        wr_pend_d = ap_take && hwrite_in;
        wr_addr_d = ap_take ? haddr_in[7:0] : wr_addr_q;
        hrdata_d  = (ap_take && !hwrite_in) ? regs.rd_data : hrdata_q;
    end

    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
            hrdata_q  <= 32'h0000_0000;
        end else begin
            wr_pend_q <= wr_pend_d;
            wr_addr_q <= wr_addr_d;
            hrdata_q  <= hrdata_d;
        end
    end

    assign regs.rd_en    = ap_take && !hwrite_in;
    assign regs.rd_addr  = haddr_in[7:0];
    assign regs.wr_en    = wr_pend_q;
    assign regs.wr_addr  = wr_addr_q;
    assign regs.wr_data  = hwdata_in;
    assign hreadyout_out = 1'b1;
    assign hresp_out     = 1'b0;
    assign hrdata_out    = hrdata_q;
endmodule : taa_ahb_port

//--- logic/taa_pick.sv
// scheduler pick: class first, then the larger age number
`timescale 1ns/1ps
module taa_pick
    import taa_pkg::*;
#(
    parameter int unsigned NT = NUM_THREADS
)(
    // clock and reset
    input  wire logic              ref_clk_in,
    input  wire logic              sys_rst_in,
    // candidate threads
    input  wire logic [NT-1:0]     cand_in,
    input  wire logic [NT-1:0]     high_class_in,
    input  wire logic [AGE_W-1:0]  age_in [NT],
    // chosen thread
    output logic                   pick_valid_out,
    output logic [SLOT_W-1:0]      pick_slot_out
);
    logic              valid_q;
    logic              valid_d;
    logic [SLOT_W-1:0] slot_q;
    logic [SLOT_W-1:0] slot_d;
    logic [AGE_W:0]    best_key;

    // ------------------------------------------------------------------
    // compare {class, age}; ages are distinct so the winner is unique
    // ------------------------------------------------------------------
    always_comb begin
        valid_d  = 1'b0;
        slot_d   = slot_q;
        best_key = '0;
        for (int unsigned i = 0; i < NT; i++) begin
            if (cand_in[i] && (!valid_d ||
                {high_class_in[i], age_in[i]} > best_key)) begin
                valid_d  = 1'b1;
                slot_d   = SLOT_W'(i);
                best_key = {high_class_in[i], age_in[i]};
            end
        end
    end

    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            valid_q <= 1'b0;
            slot_q  <= SEL_RST;
        end else begin
            valid_q <= valid_d;
            slot_q  <= slot_d;
        end
    end

    assign pick_valid_out = valid_q;
    assign pick_slot_out  = slot_q;
endmodule : taa_pick

//--- logic/taa_top.sv
// thread aging priority tracker for one execution unit, with ahb registers
//
// Summary of operation
// - a high class thread always outranks a low class thread, age aside
// - every resident thread on the execution unit holds a distinct age
// - within one class the larger age number, the older thread, wins
// - a dispatched thread starts with age zero
// - an age grows only when another thread's new or grown age reaches it
// - a restored thread gets a fresh age, the saved one is not used
// - age is zero after reset and cannot be written
// - state word shows slice 13:11, dual subslice 10:9, subslice 8
//
// Local design decisions: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
module taa_top
    import taa_pkg::*;
#(
    parameter int unsigned NT = NUM_THREADS
)(
    // clock and reset
    input  wire logic              ref_clk_in,
    input  wire logic              sys_rst_in,

    // ahb-lite slave
    input  wire logic              hsel_in,
    input  wire logic [31:0]       haddr_in,
    input  wire logic [1:0]        htrans_in,
    input  wire logic              hwrite_in,
    input  wire logic [2:0]        hsize_in,
    input  wire logic [31:0]       hwdata_in,
    input  wire logic              hready_in,
    output logic                   hreadyout_out,
    output logic                   hresp_out,
    output logic [31:0]            hrdata_out,

    // thread dispatcher
    input  wire logic              dispatch_valid_in,
    input  wire logic              restore_valid_in,
    input  wire logic [SLOT_W-1:0] dispatch_slot_in,
    input  wire logic              dispatch_class_in,
    input  wire logic              retire_valid_in,
    input  wire logic [SLOT_W-1:0] retire_slot_in,

    // thread readiness
    input  wire logic [NT-1:0]     ready_mask_in,

    // location of this execution unit
    input  wire logic [2:0]        slice_id_in,
    input  wire logic [1:0]        dss_id_in,
    input  wire logic              subslice_id_in,

    // scheduler choice
    output logic                   pick_valid_out,
    output logic [SLOT_W-1:0]      pick_slot_out,

    // per-thread view
    output logic [NT-1:0]          resident_out,
    output logic [NT-1:0]          high_class_out
);
    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic [NT-1:0]      resident_q;
    logic [NT-1:0]      resident_d;

    logic [NT-1:0]      class_q;
    logic [NT-1:0]      class_d;

    logic [AGE_W-1:0]   age_q [NT];
    logic [AGE_W-1:0]   age_d [NT];

    logic               sched_en_q;
    logic               sched_en_d;

    logic [SLOT_W-1:0]  sel_q;
    logic [SLOT_W-1:0]  sel_d;

    logic [31:0]        launch_cnt_q;
    logic [31:0]        launch_cnt_d;

    logic [31:0]        restore_cnt_q;
    logic [31:0]        restore_cnt_d;

    logic [2:0]         slice_q;
    logic [1:0]         dss_q;
    logic               subsl_q;

    logic               launch;
    logic [NT-1:0]      stays;
    logic [NT:0]        age_used;
    logic [AGE_W:0]     free_age;
    logic [NT-1:0]      cand;

    taa_reg_if regs ();

    // ------------------------------------------------------------------
    // state word formatting, used by the read mux
    // ------------------------------------------------------------------
    function automatic logic [31:0] state_word(
        input logic             hi,
        input logic [AGE_W-1:0] age,
        input logic [2:0]       slice,
        input logic [1:0]       dss,
        input logic             subsl
    );
        logic [31:0] w;

        w = 32'h0000_0000;
        w[SW_CLASS_BIT] = hi;
        w[SW_AGE_LSB +: AGE_W] = age;
        w[SW_RSVD_MSB:SW_RSVD_LSB] = 6'h00;
        w[SW_SLICE_LSB +: 3] = slice;
        w[SW_DSS_LSB +: 2] = dss;
        w[SW_SUBSL_BIT] = subsl;

        return w;
    endfunction : state_word

    // ------------------------------------------------------------------
    // bus front end
    // ------------------------------------------------------------------
    taa_ahb_port u_port (
        .ref_clk_in    (ref_clk_in),
        .sys_rst_in    (sys_rst_in),
        .hsel_in       (hsel_in),
        .haddr_in      (haddr_in),
        .htrans_in     (htrans_in),
        .hwrite_in     (hwrite_in),
        .hsize_in      (hsize_in),
        .hwdata_in     (hwdata_in),
        .hready_in     (hready_in),
        .hreadyout_out (hreadyout_out),
        .hresp_out     (hresp_out),
        .hrdata_out    (hrdata_out),
        .regs          (regs)
    );

    // ------------------------------------------------------------------
    // age tracking
    // ------------------------------------------------------------------
    always_comb begin
        // restore launches exactly like dispatch, no saved age taken
        launch = dispatch_valid_in || restore_valid_in;

        // threads that remain and keep their age bookkeeping
        for (int unsigned i = 0; i < NT; i++) begin
            stays[i] = resident_q[i]
                && !(launch && dispatch_slot_in == SLOT_W'(i))
                && !(retire_valid_in && retire_slot_in == SLOT_W'(i));
        end

        // lowest age not held: the end of the bump chain
        age_used = '0;
        for (int unsigned i = 0; i < NT; i++) begin
            if (stays[i]) begin
                age_used[age_q[i]] = 1'b1;
            end
        end

        free_age = (AGE_W+1)'(NT);
        for (int i = NT; i >= 0; i--) begin
            if (!age_used[i]) begin
                free_age = (AGE_W+1)'(i);
            end
        end

        for (int unsigned i = 0; i < NT; i++) begin
            resident_d[i] = stays[i];
            class_d[i]    = stays[i] ? class_q[i] : 1'b0;
            age_d[i]      = stays[i] ? age_q[i] : AGE_RESET;

            // the zero-aged chain moves up one, others hold
            if (launch && stays[i]
                && {1'b0, age_q[i]} < free_age) begin
                age_d[i] = age_q[i] + AGE_W'(1);
            end
            if (launch && dispatch_slot_in == SLOT_W'(i)) begin
                resident_d[i] = 1'b1;
                class_d[i]    = dispatch_class_in;
                age_d[i]      = AGE_RESET;
            end
        end
    end

    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            resident_q <= '0;
            class_q    <= '0;
            for (int unsigned i = 0; i < NT; i++) begin
                age_q[i] <= AGE_RESET;
            end
        end else begin
            resident_q <= resident_d;
            class_q    <= class_d;
            age_q      <= age_d;
        end
    end

    // ------------------------------------------------------------------
    // scheduler
    // ------------------------------------------------------------------
    always_comb begin
        cand = (sched_en_q ? ready_mask_in : '0) & resident_q;
    end

    taa_pick #(
        .NT (NT)
    ) u_pick (
        .ref_clk_in     (ref_clk_in),
        .sys_rst_in     (sys_rst_in),
        .cand_in        (cand),
        .high_class_in  (class_q),
        .age_in         (age_q),
        .pick_valid_out (pick_valid_out),
        .pick_slot_out  (pick_slot_out)
    );

    // ------------------------------------------------------------------
    // register writes and counters
    // ------------------------------------------------------------------
    always_comb begin
        sched_en_d    = sched_en_q;
        sel_d         = sel_q;
        launch_cnt_d  = launch_cnt_q + 32'(dispatch_valid_in);
        restore_cnt_d = restore_cnt_q + 32'(restore_valid_in);

        if (regs.wr_en) begin
            unique case (regs.wr_addr)
                OFS_CTRL: begin
                    sched_en_d = regs.wr_data[CTRL_SCHED_BIT];
                end
                OFS_THREAD_SEL: begin
                    sel_d = regs.wr_data[SLOT_W-1:0];
                end
                // read-only words, the age field among them, ignore writes
                default: begin
                    sched_en_d = sched_en_q;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            sched_en_q    <= CTRL_SCHED_RST;
            sel_q         <= SEL_RST;
            launch_cnt_q  <= CNT_RST;
            restore_cnt_q <= CNT_RST;

            slice_q       <= 3'h0;
            dss_q         <= 2'h0;
            subsl_q       <= 1'b0;
        end else begin
            sched_en_q    <= sched_en_d;
            sel_q         <= sel_d;
            launch_cnt_q  <= launch_cnt_d;
            restore_cnt_q <= restore_cnt_d;

            slice_q       <= slice_id_in;
            dss_q         <= dss_id_in;
            subsl_q       <= subslice_id_in;
        end
    end

    // ------------------------------------------------------------------
    // register reads
    // ------------------------------------------------------------------
    always_comb begin
        regs.rd_data = 32'h0000_0000;

        if (regs.rd_en) begin
            unique case (regs.rd_addr)
                OFS_CTRL: begin
                    regs.rd_data[CTRL_SCHED_BIT] = sched_en_q;
                end
                OFS_THREAD_SEL: begin
                    regs.rd_data[SLOT_W-1:0] = sel_q;
                end
                OFS_STATE_WORD0: begin
                    regs.rd_data = state_word(class_q[sel_q],
                        age_q[sel_q], slice_q, dss_q, subsl_q);
                end
                OFS_RESIDENT: begin
                    regs.rd_data[NT-1:0] = resident_q;
                    regs.rd_data[RES_CLASS_LSB +: NT] = class_q;
                end
                OFS_PICK: begin
                    regs.rd_data[PICK_VALID_BIT] = pick_valid_out;
                    regs.rd_data[SLOT_W-1:0]     = pick_slot_out;
                end
                OFS_LAUNCH_CNT: begin
                    regs.rd_data = launch_cnt_q;
                end
                OFS_RESTORE_CNT: begin
                    regs.rd_data = restore_cnt_q;
                end
                default: begin
                    regs.rd_data = 32'h0000_0000;
                end
            endcase
        end
    end

    assign resident_out   = resident_q;
    assign high_class_out = class_q;
endmodule : taa_top

//--- verification/taa_top_monitor.sv
// port checker of the thread aging priority block
`timescale 1ns/1ps
module taa_top_monitor
    import taa_pkg::*;
#(
    parameter int unsigned NT = NUM_THREADS
)(
    // clock and reset
    input wire logic              ref_clk_in,
    input wire logic              sys_rst_in,
    // ahb-lite slave
    input wire logic              hsel_in,
    input wire logic [31:0]       haddr_in,
    input wire logic [1:0]        htrans_in,
    input wire logic              hwrite_in,
    input wire logic [2:0]        hsize_in,
    input wire logic              hready_in,
    input wire logic [31:0]       hrdata_out,
    // thread dispatcher
    input wire logic              dispatch_valid_in,
    input wire logic              restore_valid_in,
    input wire logic [SLOT_W-1:0] dispatch_slot_in,
    input wire logic              dispatch_class_in,
    input wire logic              retire_valid_in,
    input wire logic [SLOT_W-1:0] retire_slot_in,
    // readiness and location
    input wire logic [NT-1:0]     ready_mask_in,
    input wire logic [2:0]        slice_id_in,
    input wire logic [1:0]        dss_id_in,
    input wire logic              subslice_id_in,
    // scheduler and per-thread view
    input wire logic              pick_valid_out,
    input wire logic [SLOT_W-1:0] pick_slot_out,
    input wire logic [NT-1:0]     resident_out,
    input wire logic [NT-1:0]     high_class_out
);
    // -------------
    // helper state
    // -------------
    logic [NT-1:0] res_q, rdy_q, cls_q;
    logic          sw_rd_q, launch;
    assign launch = dispatch_valid_in | restore_valid_in;
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            {res_q, rdy_q, cls_q, sw_rd_q} <= '0;
        end else begin
            res_q   <= resident_out;
            rdy_q   <= ready_mask_in;
            cls_q   <= high_class_out;
            sw_rd_q <= hsel_in & htrans_in[1] & ~hwrite_in & hready_in
                       & (hsize_in == 3'h2)
                       & (haddr_in[7:0] == OFS_STATE_WORD0);
        end
    end
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (sys_rst_in);
    // -------------
    // properties
    // -------------
    property p_launch_res;
        launch |=> resident_out[$past(dispatch_slot_in)];
    endproperty
    a_launch_res: assert property (p_launch_res)
        else $error("launched slot not resident");
    property p_launch_cls;
        launch |=> high_class_out[$past(dispatch_slot_in)]
                   == $past(dispatch_class_in);
    endproperty
    a_launch_cls: assert property (p_launch_cls)
        else $error("launched slot class wrong");
    property p_retire;
        retire_valid_in && !(launch && dispatch_slot_in == retire_slot_in)
        |=> !resident_out[$past(retire_slot_in)];
    endproperty
    a_retire: assert property (p_retire)
        else $error("retired slot still resident");
    property p_hold;
        !launch && !retire_valid_in
        |=> $stable(resident_out) && $stable(high_class_out);
    endproperty
    a_hold: assert property (p_hold)
        else $error("thread state changed without a request");
    property p_pick_cand;
        pick_valid_out |-> res_q[pick_slot_out] && rdy_q[pick_slot_out];
    endproperty
    a_pick_cand: assert property (p_pick_cand)
        else $error("pick is not a ready resident thread");
    property p_pick_cls;
        pick_valid_out && !cls_q[pick_slot_out]
        |-> (res_q & rdy_q & cls_q) == '0;
    endproperty
    a_pick_cls: assert property (p_pick_cls)
        else $error("low class picked over high class");
    property p_sw_rsvd;
        sw_rd_q |-> hrdata_out[19:14] == 6'h00 && hrdata_out[31:24] == 8'h00;
    endproperty
    a_sw_rsvd: assert property (p_sw_rsvd)
        else $error("state word reserved bits not zero");
    property p_sw_loc;
        sw_rd_q |-> hrdata_out[13:8] == {$past(slice_id_in, 2),
                    $past(dss_id_in, 2), $past(subslice_id_in, 2)};
    endproperty
    a_sw_loc: assert property (p_sw_loc)
        else $error("state word location fields wrong");
    c_launch: cover property (launch ##1 resident_out != '0);
    c_pick_hi: cover property (pick_valid_out && cls_q[pick_slot_out]);
    c_sw_rd: cover property (sw_rd_q);
endmodule : taa_top_monitor

bind taa_top taa_top_monitor #(.NT(NT)) taa_top_monitor_inst (
    .ref_clk_in, .sys_rst_in, .hsel_in, .haddr_in, .htrans_in,
    .hwrite_in, .hsize_in, .hready_in, .hrdata_out,
    .dispatch_valid_in, .restore_valid_in,
    .dispatch_slot_in, .dispatch_class_in, .retire_valid_in,
    .retire_slot_in, .ready_mask_in, .slice_id_in, .dss_id_in,
    .subslice_id_in, .pick_valid_out, .pick_slot_out, .resident_out,
    .high_class_out);

//--- verification/taa_disp_model.sv
// thread dispatcher model driving launches and retirements
`timescale 1ns/1ps
module taa_disp_model
    import taa_pkg::*;
(
    // clock
    input  wire logic              ref_clk_in,
    // launch and retire requests
    output logic                   dispatch_valid_out,
    output logic                   restore_valid_out,
    output logic [SLOT_W-1:0]      dispatch_slot_out,
    output logic                   dispatch_class_out,
    output logic                   retire_valid_out,
    output logic [SLOT_W-1:0]      retire_slot_out
);
    initial begin
        {dispatch_valid_out, restore_valid_out, dispatch_slot_out,
         dispatch_class_out, retire_valid_out, retire_slot_out} = '0;
    end
    // one-cycle launch pulse; qualifiers scrambled once it is over
    task automatic launch(input logic [SLOT_W-1:0] s, input logic c,
                          input logic rs);
        @(posedge ref_clk_in);
        dispatch_valid_out <= ~rs;
        restore_valid_out  <= rs;
        dispatch_slot_out  <= s;
        dispatch_class_out <= c;
        @(posedge ref_clk_in);
        dispatch_valid_out <= 1'b0;
        restore_valid_out  <= 1'b0;
        dispatch_slot_out  <= ~s;
        dispatch_class_out <= ~c;
    endtask : launch
    task automatic retire(input logic [SLOT_W-1:0] s);
        @(posedge ref_clk_in);
        retire_valid_out <= 1'b1;
        retire_slot_out  <= s;
        @(posedge ref_clk_in);
        retire_valid_out <= 1'b0;
        retire_slot_out  <= ~s;
    endtask : retire
endmodule : taa_disp_model

//--- verification/taa_top_tb.sv
// self-checking bench of the thread aging priority block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
    $display("wrong value %s exp %h got %h", nm, e, g); end end
module taa_top_tb
    import taa_pkg::*;
;
    logic              clk, hsel = 1'b0, hwrite = 1'b0, rst = 1'b1;
    logic              loc_sub = 1'b1;
    logic [31:0]       haddr = 32'h0, hwdata = 32'h0, rd;
    logic [2:0]        hsize = 3'h2, loc_slice = 3'h5;
    logic [1:0]        htrans = 2'h0, loc_dss = 2'h2;
    logic [7:0]        ready_mask = 8'hFF;
    wire               hready, hresp, d_v, r_v, d_c, t_v, pick_v;
    wire [31:0]        hrdata;
    wire [SLOT_W-1:0]  d_s, t_s, pick_s;
    int                n_fail = 0, n_compared = 0, cyc = 0;
    logic [7:0]        pm [3] = '{8'hFF, 8'hDF, 8'hDE};
    logic [2:0]        ps [3] = '{3'h5, 3'h0, 3'h1};
    taa_top taa_top_inst (
        .ref_clk_in(clk), .sys_rst_in(rst), .hsel_in(hsel),
        .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
        .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hready),
        .hreadyout_out(hready), .hresp_out(hresp), .hrdata_out(hrdata),
        .dispatch_valid_in(d_v), .restore_valid_in(r_v),
        .dispatch_slot_in(d_s), .dispatch_class_in(d_c),
        .retire_valid_in(t_v), .retire_slot_in(t_s),
        .ready_mask_in(ready_mask), .slice_id_in(loc_slice),
        .dss_id_in(loc_dss), .subslice_id_in(loc_sub),
        .pick_valid_out(pick_v), .pick_slot_out(pick_s),
        .resident_out(), .high_class_out());
    taa_disp_model taa_disp_model_inst (
        .ref_clk_in(clk), .dispatch_valid_out(d_v),
        .restore_valid_out(r_v), .dispatch_slot_out(d_s),
        .dispatch_class_out(d_c), .retire_valid_out(t_v),
        .retire_slot_out(t_s));
    // -------------
    // clock, timeout and tasks
    // -------------
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : finish_test
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            finish_test();
        end
    end
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        hsel   <= 1'b1;
        haddr  <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clk); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= w ? d : 32'h0000_0000;
        do @(posedge clk); while (hready !== 1'b1);
        q = hrdata;
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d, rd);
    endtask : wr
    task automatic rdchk(string nm, input logic [7:0] a, logic [31:0] e);
        bus(1'b0, a, 32'h0000_0000, rd);
        `CHK(nm, {1'b0, e}, {hresp, rd})
    endtask : rdchk
    function automatic logic [31:0] sw(input logic c, logic [2:0] age);
        return {8'h00, c, age, 6'h00, loc_slice, loc_dss, loc_sub, 8'h00};
    endfunction : sw
    task automatic chk_all(input logic [23:0] ag, logic [7:0] m, c);
        rdchk("resident", OFS_RESIDENT, {16'h0000, c, m});
        for (int i = 0; i < 8; i++) begin
            if (m[i]) begin
                wr(OFS_THREAD_SEL, 32'(i));
                rdchk("state word", OFS_STATE_WORD0, sw(c[i], ag[3*i+:3]));
            end
        end
    endtask : chk_all
    // -------------
    // main sequence
    // -------------
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rdchk("ctrl", OFS_CTRL, 32'h0000_0001);
        rdchk("word0", OFS_STATE_WORD0, sw(1'b0, 3'h0));
        rdchk("pick", OFS_PICK, 32'h0000_0000);
        rdchk("unmapped", 8'h1C, 32'h0000_0000);
        for (int i = 0; i < 4; i++) taa_disp_model_inst.launch(3'(i), 0, 0);
        wr(OFS_STATE_WORD0, 32'hFFFF_FFFF);
        chk_all(24'h000053, 8'h0F, 8'h00);
        taa_disp_model_inst.retire(3'h2);
        taa_disp_model_inst.launch(3'h4, 1'b0, 1'b0);
        chk_all(24'h000213, 8'h1B, 8'h00);
        taa_disp_model_inst.launch(3'h5, 1'b1, 1'b1);
        chk_all(24'h00141C, 8'h3B, 8'h20);
        taa_disp_model_inst.launch(3'h6, 1'b0, 1'b0);
        taa_disp_model_inst.launch(3'h7, 1'b0, 1'b0);
        taa_disp_model_inst.launch(3'h2, 1'b0, 1'b0);
        chk_all(24'h29CA37, 8'hFF, 8'h20);
        rdchk("launches", OFS_LAUNCH_CNT, 32'h0000_0008);
        rdchk("restores", OFS_RESTORE_CNT, 32'h0000_0001);
        for (int i = 0; i < 3; i++) begin
            ready_mask <= pm[i];
            repeat (3) @(posedge clk);
            `CHK("pick slot", ps[i], pick_s)
            rdchk("pick", OFS_PICK, {23'h0, 1'b1, 5'h00, ps[i]});
        end
        wr(OFS_CTRL, 32'h0000_0000);
        repeat (3) @(posedge clk);
        `CHK("pick valid", 1'b0, pick_v)
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        chk_all(24'h000000, 8'h00, 8'h00);
        rdchk("word0", OFS_STATE_WORD0, sw(1'b0, 3'h0));
        finish_test();
    end
endmodule : taa_top_tb
